// >>> psl_pkg.sv
/*
  Shared constants and types for the strap configuration loader: register
  offsets and field positions, reset values, mode codes, loader states and the
  structs that carry decoded and active configuration.
  Assumes a 32-bit APB register bus with byte addresses and one word a register.
*/
`default_nettype none
package psl_pkg;

  // ****************************************************************
  // Bus and register map
  // ****************************************************************
  localparam int        APB_AW          = 8;
  localparam int        APB_DW          = 32;
  localparam logic [7:0] OFS_BASIC_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADVERT     = 8'h04;
  localparam logic [7:0] OFS_SPECIAL    = 8'h08;
  localparam logic [7:0] OFS_STRAP_STAT = 8'h0C;
  localparam logic [7:0] OFS_LINK_CFG   = 8'h10;

  // Basic control fields
  localparam int BC_SOFT_RST = 15;
  localparam int BC_SPEED    = 13;
  localparam int BC_ANEG     = 12;
  localparam int BC_PWRDN    = 11;
  localparam int BC_BIT10    = 10;
  localparam int BC_DUPLEX   = 8;

  // Advertisement and special modes fields
  localparam int ADV_LSB     = 5;
  localparam int ADV_W       = 4;
  localparam int SM_ADDR_LSB = 0;
  localparam int SM_ADDR_W   = 5;
  localparam int SM_MODE_LSB = 5;
  localparam int SM_MODE_W   = 3;
  localparam int SM_IFACE    = 14;

  // Strap status and link configuration fields
  localparam int SS_ADDR_LSB    = 0;
  localparam int SS_MODE_LSB    = 4;
  localparam int SS_IFACE       = 8;
  localparam int SS_REGULATOR_DISABLE_STRAP      = 9;
  localparam int SS_REG_SAMPLED = 10;
  localparam int SS_STATE_LSB   = 12;
  localparam int LC_CRS_TX      = 0;
  localparam int LC_REPEATER    = 1;
  localparam int LC_PWRDN       = 2;
  localparam int LC_CORE_REG_EN = 3;

  // ****************************************************************
  // Shared pads and reset values
  // ****************************************************************
  localparam int STRAP_AW  = 3;
  localparam int NUM_PADS  = 6;
  localparam int PAD_ADDR0 = 0;
  localparam int PAD_MODE0 = 3;
  localparam int NUM_SYNC  = NUM_PADS + 4;

  localparam logic [SM_ADDR_W-1:0] ADDR_FIELD_RST = 5'h00;
  localparam logic [SM_MODE_W-1:0] MODE_FIELD_RST = 3'h0;
  localparam logic [3:0]           CTRL_RST       = 4'h0;
  localparam logic [ADV_W-1:0]     ADV_RST        = 4'h0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    MODE_10_HALF   = 3'h0,
    MODE_10_FULL   = 3'h1,
    MODE_100_HALF  = 3'h2,
    MODE_100_FULL  = 3'h3,
    MODE_AN_100HD  = 3'h4,
    MODE_REPEATER  = 3'h5,
    MODE_PWRDN     = 3'h6,
    MODE_ALL_CAP   = 3'h7
  } psl_mode_e;

  // Gray coded along reset -> capture -> run -> soft reset -> run
  typedef enum logic [1:0] {
    ST_RESET   = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_RUN     = 2'b11,
    ST_SOFT    = 2'b10
  } psl_state_e;

  // Register loads for one mode code; ctrl is {b13,b12,b10,b8}
  typedef struct packed {
    logic             ctrl_load;
    logic [3:0]       ctrl;
    logic             adv_load;
    logic [ADV_W-1:0] adv;
    logic             crs_tx;
    logic             repeater;
    logic             power_down;
  } psl_mode_cfg_s;

  // Active configuration handed to the 10/100 logic
  typedef struct packed {
    logic                 speed100;
    logic                 aneg_en;
    logic                 bit10;
    logic                 full_duplex;
    logic                 power_down;
    logic [ADV_W-1:0]     adv;
    logic                 crs_tx;
    logic                 repeater;
    logic                 rmii_sel;
    logic [SM_ADDR_W-1:0] mgmt_addr;
  } psl_phy_cfg_s;

endpackage : psl_pkg
`default_nettype wire

// >>> psl_sync.sv
/*
  Two flip-flop synchroniser for a bundle of asynchronous levels.
  Assumes each bit is an independent level; multi-bit words are not coherent.
*/
`timescale 1ns/10ps
`default_nettype none
module psl_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,     // System clock
  input  wire logic         sys_rst, // Synchronous reset, active high
  input  wire logic [W-1:0] d,       // Asynchronous levels
  output logic      [W-1:0] q        // Synchronised levels
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_d;

  // ****************************************************************
  // Next values
  // ****************************************************************
  always_comb begin
    meta_d = d;
    sync_d = meta_q;
  end

  // Two stages; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= meta_d;
      q      <= sync_d;
    end
  end

endmodule : psl_sync
`default_nettype wire

// >>> psl_mode_decode.sv
/*
  Maps a three-bit operating mode code onto the control and advertisement
  register loads and the carrier sense and repeater behaviour.
  Pure combinational; the caller registers the result.
*/
`timescale 1ns/10ps
`default_nettype none
module psl_mode_decode
  import psl_pkg::*;
(
  input  wire logic [SM_MODE_W-1:0] mode, // Mode code
  output psl_mode_cfg_s             cfg   // Register loads for that code
);

  // ****************************************************************
  // Mode table
  // ****************************************************************
  always_comb begin
    cfg = '0;
    case (psl_mode_e'(mode))
      MODE_10_HALF: begin
        cfg.ctrl_load = 1'b1;
        cfg.ctrl      = 4'h0;
        cfg.crs_tx    = 1'b1;
      end
      MODE_10_FULL: begin
        cfg.ctrl_load = 1'b1;
        cfg.ctrl      = 4'h1;
      end
      MODE_100_HALF: begin
        cfg.ctrl_load = 1'b1;
        cfg.ctrl      = 4'h8;
        cfg.crs_tx    = 1'b1;
      end
      MODE_100_FULL: begin
        cfg.ctrl_load = 1'b1;
        cfg.ctrl      = 4'h9;
      end
      MODE_AN_100HD: begin
        cfg.ctrl_load = 1'b1;
        cfg.ctrl      = 4'hC;
        cfg.adv_load  = 1'b1;
        cfg.adv       = 4'h4;
        cfg.crs_tx    = 1'b1;
      end
      MODE_REPEATER: begin
        cfg.ctrl_load = 1'b1;
        cfg.ctrl      = 4'hC;
        cfg.adv_load  = 1'b1;
        cfg.adv       = 4'h4;
        cfg.repeater  = 1'b1;
      end
      MODE_PWRDN: begin
        cfg.power_down = 1'b1;
      end
      MODE_ALL_CAP: begin
        cfg.ctrl_load = 1'b1;
        cfg.ctrl      = 4'hD;
        cfg.adv_load  = 1'b1;
        cfg.adv       = 4'hF;
        cfg.crs_tx    = 1'b1;
      end
      default: begin
        cfg = '0;
      end
    endcase
  end

endmodule : psl_mode_decode
`default_nettype wire

// >>> psl_strap_loader.sv
/*
  Strap configuration loader: samples the management address, operating mode,
  interface select and regulator straps, loads the configuration registers
  from them and exposes those registers on an APB slave.
  Assumes clk is the reference clock, sys_rst is power-on reset, and all pad
  and pin inputs are asynchronous to clk.
*/
// Behaviour
// - three address straps select address 0..7
// - software may rewrite address field, beyond 7
// - address straps share rx pins, sampled in reset
// - hardware reset release loads regs from mode
// - soft reset ignores straps, uses register values
// - codes 000/001 force 10 Mb/s half/full
// - codes 010/011 force 100 Mb/s half/full
// - code 100 autoneg advertising 100 half only
// - code 101 repeater, same ctrl and adv loads as 100, crs_tx off
// - code 111 autoneg with all abilities advertised
// - mode straps share rx pins, sampled in reset
// - interface strap latched at reset release, high=RMII
// - interface mode bit loaded and shows mode
// - regulator strap high at power-on disables regulator
// - regulator strap low or floating enables regulator
// - address latched at reset end, matches frames
`timescale 1ns/10ps
`default_nettype none
module psl_strap_loader
  import psl_pkg::*;
(
  input  wire logic                 clk,                     // Reference clock, 40 MHz
  input  wire logic                 sys_rst,                 // Power-on reset, sync, active high
  input  wire logic                 hw_reset_n,              // Hardware reset pin, active low
  input  wire logic                 supply_ok,               // Supplies within spec
  input  wire logic [NUM_PADS-1:0]  strap_pad_i,             // Shared rx pads, input side
  output logic      [NUM_PADS-1:0]  strap_pad_o,             // Shared rx pads, output side
  output logic      [NUM_PADS-1:0]  strap_pad_oe,            // Shared rx pads, drive enable
  input  wire logic [NUM_PADS-1:0]  rx_drive_d,              // Receive data for the pads
  input  wire logic                 iface_select_strap,      // High selects RMII
  input  wire logic                 regulator_disable_strap, // High keeps regulator off
  input  wire logic                 psel,                    // APB select
  input  wire logic                 penable,                 // APB enable
  input  wire logic                 pwrite,                  // APB write
  input  wire logic [APB_AW-1:0]    paddr,                   // APB byte address
  input  wire logic [APB_DW-1:0]    pwdata,                  // APB write data
  output logic      [APB_DW-1:0]    prdata,                  // APB read data
  output logic                      pready,                  // APB ready
  output logic                      pslverr,                 // APB error, unmapped
  input  wire logic [SM_ADDR_W-1:0] frame_addr,              // Address field of a frame
  output logic                      addr_match,              // Frame is for this device
  output psl_phy_cfg_s              phy_cfg,                 // Active configuration
  output logic                      core_regulator_en,       // Internal regulator on
  output logic                      in_reset                 // Loader held in reset
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [NUM_SYNC-1:0]  sync_q;
  logic [NUM_PADS-1:0]  pads_s;
  logic                 hw_n_s;
  logic                 iface_s;
  logic                 regulator_disable_strap_s;
  logic                 supply_s;

  psl_state_e           state_q, state_d;
  logic [STRAP_AW-1:0]  strap_addr_q, strap_addr_d;
  logic [SM_MODE_W-1:0] strap_mode_q, strap_mode_d;
  logic                 strap_iface_q, strap_iface_d;

  logic [3:0]           ctrl_q, ctrl_d;
  logic                 pwrdn_q, pwrdn_d;
  logic [ADV_W-1:0]     adv_q, adv_d;
  logic                 crs_tx_q, crs_tx_d;
  logic                 repeater_q, repeater_d;
  logic [SM_MODE_W-1:0] mode_field_q, mode_field_d;
  logic [SM_ADDR_W-1:0] addr_field_q, addr_field_d;
  logic                 iface_q, iface_d;

  logic                 supply_prev_q, supply_prev_d;
  logic                 reg_sampled_q, reg_sampled_d;
  logic                 regulator_disable_strap_q, regulator_disable_strap_d;

  logic [APB_DW-1:0]    prdata_q, prdata_d;
  logic                 pslverr_q, pslverr_d;
  logic [NUM_PADS-1:0]  pad_o_q, pad_o_d;
  logic                 pad_oe_q, pad_oe_d;

  logic [SM_MODE_W-1:0] dec_mode;
  psl_mode_cfg_s        dec_cfg;
  logic                 setup_ph;
  logic                 wr_en;
  logic                 soft_req;
  logic                 hit;
  logic [APB_DW-1:0]    rd_mux;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  psl_sync #(
    .W (NUM_SYNC)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       ({supply_ok, regulator_disable_strap, iface_select_strap, hw_reset_n, strap_pad_i}),
    .q       (sync_q)
  );

  // Split synchronised bundle
  assign pads_s   = sync_q[NUM_PADS-1:0];
  assign hw_n_s   = sync_q[NUM_PADS];
  assign iface_s  = sync_q[NUM_PADS+1];
  assign regulator_disable_strap_s = sync_q[NUM_PADS+2];
  assign supply_s = sync_q[NUM_PADS+3];

  // ****************************************************************
  // Mode decoder
  // ****************************************************************
  // Straps after hardware reset, register field after soft reset
  assign dec_mode = (state_q == ST_CAPTURE) ? strap_mode_q : mode_field_q;

  psl_mode_decode u_decode (
    .mode (dec_mode),
    .cfg  (dec_cfg)
  );

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Writes land only once the loader runs
  assign setup_ph = psel & ~penable;
  assign wr_en    = psel & penable & pwrite & (state_q == ST_RUN);
  assign soft_req = wr_en & (paddr == OFS_BASIC_CTRL) & pwdata[BC_SOFT_RST];

  // Read mux and address hit
  always_comb begin
    rd_mux = '0;
    hit    = 1'b1;
    case (paddr)
      OFS_BASIC_CTRL: begin
        rd_mux[BC_SOFT_RST] = (state_q == ST_SOFT);
        rd_mux[BC_SPEED]    = ctrl_q[3];
        rd_mux[BC_ANEG]     = ctrl_q[2];
        rd_mux[BC_PWRDN]    = pwrdn_q;
        rd_mux[BC_BIT10]    = ctrl_q[1];
        rd_mux[BC_DUPLEX]   = ctrl_q[0];
      end
      OFS_ADVERT: begin
        rd_mux[ADV_LSB +: ADV_W] = adv_q;
      end
      OFS_SPECIAL: begin
        rd_mux[SM_ADDR_LSB +: SM_ADDR_W] = addr_field_q;
        rd_mux[SM_MODE_LSB +: SM_MODE_W] = mode_field_q;
        rd_mux[SM_IFACE]                 = iface_q;
      end
      OFS_STRAP_STAT: begin
        rd_mux[SS_ADDR_LSB +: STRAP_AW]  = strap_addr_q;
        rd_mux[SS_MODE_LSB +: SM_MODE_W] = strap_mode_q;
        rd_mux[SS_IFACE]                 = strap_iface_q;
        rd_mux[SS_REGULATOR_DISABLE_STRAP]                = regulator_disable_strap_q;
        rd_mux[SS_REG_SAMPLED]           = reg_sampled_q;
        rd_mux[SS_STATE_LSB +: 2]        = state_q;
      end
      OFS_LINK_CFG: begin
        rd_mux[LC_CRS_TX]      = crs_tx_q;
        rd_mux[LC_REPEATER]    = repeater_q;
        rd_mux[LC_PWRDN]       = pwrdn_q;
        rd_mux[LC_CORE_REG_EN] = reg_sampled_q & ~regulator_disable_strap_q;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Loader state machine
  // ****************************************************************
  // Pin reset overrides every state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RESET: begin
        if (hw_n_s) begin
          state_d = ST_CAPTURE;
        end
      end
      ST_CAPTURE: begin
        state_d = ST_RUN;
      end
      ST_RUN: begin
        if (soft_req) begin
          state_d = ST_SOFT;
        end
      end
      ST_SOFT: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
    if (!hw_n_s) begin
      state_d = ST_RESET;
    end
  end

  // ****************************************************************
  // Strap holding registers
  // ****************************************************************
  // Captured once, on the edge that sees reset released
  always_comb begin
    strap_addr_d  = strap_addr_q;
    strap_mode_d  = strap_mode_q;
    strap_iface_d = strap_iface_q;
    if ((state_q == ST_RESET) && hw_n_s) begin
      strap_addr_d  = pads_s[PAD_ADDR0 +: STRAP_AW];
      strap_mode_d  = pads_s[PAD_MODE0 +: SM_MODE_W];
      strap_iface_d = iface_s;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_comb begin
    ctrl_d       = ctrl_q;
    pwrdn_d      = pwrdn_q;
    adv_d        = adv_q;
    crs_tx_d     = crs_tx_q;
    repeater_d   = repeater_q;
    mode_field_d = mode_field_q;
    addr_field_d = addr_field_q;
    iface_d      = iface_q;
    case (state_q)
      ST_RESET: begin
        ctrl_d       = CTRL_RST;
        pwrdn_d      = 1'b0;
        adv_d        = ADV_RST;
        crs_tx_d     = 1'b0;
        repeater_d   = 1'b0;
        mode_field_d = MODE_FIELD_RST;
        addr_field_d = ADDR_FIELD_RST;
        iface_d      = 1'b0;
      end
      ST_CAPTURE, ST_SOFT: begin
        if (dec_cfg.ctrl_load) begin
          ctrl_d = dec_cfg.ctrl;
        end
        if (dec_cfg.adv_load) begin
          adv_d = dec_cfg.adv;
        end
        pwrdn_d    = dec_cfg.power_down;
        crs_tx_d   = dec_cfg.crs_tx;
        repeater_d = dec_cfg.repeater;
        if (state_q == ST_CAPTURE) begin
          mode_field_d = strap_mode_q;
          addr_field_d = {{(SM_ADDR_W-STRAP_AW){1'b0}}, strap_addr_q};
          iface_d      = strap_iface_q;
        end
      end
      ST_RUN: begin
        if (wr_en && (paddr == OFS_BASIC_CTRL)) begin
          ctrl_d  = {pwdata[BC_SPEED], pwdata[BC_ANEG], pwdata[BC_BIT10], pwdata[BC_DUPLEX]};
          pwrdn_d = pwdata[BC_PWRDN];
        end
        if (wr_en && (paddr == OFS_ADVERT)) begin
          adv_d = pwdata[ADV_LSB +: ADV_W];
        end
        if (wr_en && (paddr == OFS_SPECIAL)) begin
          addr_field_d = pwdata[SM_ADDR_LSB +: SM_ADDR_W];
          mode_field_d = pwdata[SM_MODE_LSB +: SM_MODE_W];
        end
      end
      default: begin
        ctrl_d = CTRL_RST;
      end
    endcase
  end

  // ****************************************************************
  // Regulator strap, sampled once per power-on
  // ****************************************************************
  always_comb begin
    supply_prev_d = supply_s;
    reg_sampled_d = reg_sampled_q;
    regulator_disable_strap_d      = regulator_disable_strap_q;
    if (supply_s && !supply_prev_q && !reg_sampled_q) begin
      regulator_disable_strap_d      = regulator_disable_strap_s;
      reg_sampled_d = 1'b1;
    end
  end

  // ****************************************************************
  // Bus answer and pad drive
  // ****************************************************************
  always_comb begin
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    if (setup_ph) begin
      prdata_d  = rd_mux;
      pslverr_d = ~hit;
    end
    pad_o_d  = rx_drive_d;
    pad_oe_d = (state_d == ST_RUN) || (state_d == ST_SOFT);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q       <= ST_RESET;
      strap_addr_q  <= '0;
      strap_mode_q  <= MODE_FIELD_RST;
      strap_iface_q <= 1'b0;
      ctrl_q        <= CTRL_RST;
      pwrdn_q       <= 1'b0;
      adv_q         <= ADV_RST;
      crs_tx_q      <= 1'b0;
      repeater_q    <= 1'b0;
      mode_field_q  <= MODE_FIELD_RST;
      addr_field_q  <= ADDR_FIELD_RST;
      iface_q       <= 1'b0;
      supply_prev_q <= 1'b0;
      reg_sampled_q <= 1'b0;
      regulator_disable_strap_q      <= 1'b0;
      prdata_q      <= '0;
      pslverr_q     <= 1'b0;
      pad_o_q       <= '0;
      pad_oe_q      <= 1'b0;
    end else begin
      state_q       <= state_d;
      strap_addr_q  <= strap_addr_d;
      strap_mode_q  <= strap_mode_d;
      strap_iface_q <= strap_iface_d;
      ctrl_q        <= ctrl_d;
      pwrdn_q       <= pwrdn_d;
      adv_q         <= adv_d;
      crs_tx_q      <= crs_tx_d;
      repeater_q    <= repeater_d;
      mode_field_q  <= mode_field_d;
      addr_field_q  <= addr_field_d;
      iface_q       <= iface_d;
      supply_prev_q <= supply_prev_d;
      reg_sampled_q <= reg_sampled_d;
      regulator_disable_strap_q      <= regulator_disable_strap_d;
      prdata_q      <= prdata_d;
      pslverr_q     <= pslverr_d;
      pad_o_q       <= pad_o_d;
      pad_oe_q      <= pad_oe_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata       = prdata_q;
  assign pslverr      = pslverr_q;
  assign pready       = psel & penable;
  assign strap_pad_o  = pad_o_q;
  assign strap_pad_oe = {NUM_PADS{pad_oe_q}};
  assign in_reset     = (state_q == ST_RESET);

  // Frames answered only at the active address
  assign addr_match = (frame_addr == addr_field_q) && (state_q == ST_RUN);

  // Regulator on once the strap is sampled, unless it read high
  assign core_regulator_en = reg_sampled_q & ~regulator_disable_strap_q;

  // Active configuration from the registers
  always_comb begin
    phy_cfg             = '0;
    phy_cfg.speed100    = ctrl_q[3];
    phy_cfg.aneg_en     = ctrl_q[2];
    phy_cfg.bit10       = ctrl_q[1];
    phy_cfg.full_duplex = ctrl_q[0];
    phy_cfg.power_down  = pwrdn_q;
    phy_cfg.adv         = adv_q;
    phy_cfg.crs_tx      = crs_tx_q;
    phy_cfg.repeater    = repeater_q;
    phy_cfg.rmii_sel    = iface_q;
    phy_cfg.mgmt_addr   = addr_field_q;
  end

endmodule : psl_strap_loader
`default_nettype wire

// >>> psl_strap_loader_sva.sv
/* Port checker for the strap loader.
   Bound to the loader from the testbench top. */
`timescale 1ns/10ps
`default_nettype none
module psl_strap_loader_sva
  import psl_pkg::*;
(
  input wire logic                 clk,          // Clock
  input wire logic                 sys_rst,      // Reset
  input wire logic                 hw_reset_n,   // Reset pin
  input wire logic                 psel,         // Select
  input wire logic                 penable,      // Enable
  input wire logic                 pready,       // Ready
  input wire logic [NUM_PADS-1:0]  rx_drive_d,   // Pad data
  input wire logic [NUM_PADS-1:0]  strap_pad_o,  // Pad out
  input wire logic [NUM_PADS-1:0]  strap_pad_oe, // Pad enable
  input wire logic [SM_ADDR_W-1:0] frame_addr,   // Frame address
  input wire logic                 addr_match,   // Match
  input wire psl_phy_cfg_s         phy_cfg,      // Config
  input wire logic                 in_reset      // In reset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Bus, pad and reset relations
  property p_rdy; pready == (psel && penable); endproperty
  a_rdy: assert property (p_rdy) else $error("ready wrong");
  property p_oe; in_reset |-> strap_pad_oe == '0; endproperty
  a_oe: assert property (p_oe) else $error("pad driven in reset");
  property p_run; $fell(in_reset) |=> strap_pad_oe == '1; endproperty
  a_run: assert property (p_run) else $error("pad not driven");
  property p_pad; !in_reset |=> strap_pad_o == $past(rx_drive_d); endproperty
  a_pad: assert property (p_pad) else $error("pad data wrong");
  property p_match; addr_match |-> frame_addr == phy_cfg.mgmt_addr && !in_reset; endproperty
  a_match: assert property (p_match) else $error("bad match");
  property p_hold; !hw_reset_n [*3] |=> in_reset; endproperty
  a_hold: assert property (p_hold) else $error("reset not held");
  property p_dflt; in_reset [*2] |-> phy_cfg.mgmt_addr == '0 && phy_cfg.adv == '0; endproperty
  a_dflt: assert property (p_dflt) else $error("no defaults");
  property p_rel; $rose(hw_reset_n) |-> ##[2:4] !in_reset; endproperty
  a_rel: assert property (p_rel) else $error("late release");
endmodule : psl_strap_loader_sva
`default_nettype wire

// >>> psl_strap_model.sv
/* Strap resistors on the shared receive pads.
   Assumes the loader drives pads only while enabled. */
`timescale 1ns/10ps
`default_nettype none
module psl_strap_model
  import psl_pkg::*;
(
  input  wire logic [NUM_PADS-1:0] strap_val,    // Resistor levels
  input  wire logic [NUM_PADS-1:0] strap_pad_o,  // Loader data
  input  wire logic [NUM_PADS-1:0] strap_pad_oe, // Loader enable
  output logic      [NUM_PADS-1:0] strap_pad_i   // Pad level
);
  // Driven pads win, else resistor level
  assign strap_pad_i = (strap_pad_oe & strap_pad_o) | (~strap_pad_oe & strap_val);
endmodule : psl_strap_model
`default_nettype wire

// >>> psl_strap_loader_tb.sv
/* Testbench: strap codes, APB access, soft reset, regulator.
   Assumes checker and strap model compiled first. */
`timescale 1ns/10ps
`default_nettype none
module psl_strap_loader_tb
  import psl_pkg::*;
;
  logic                 clk = 1'b0, sys_rst = 1'b1, hw_reset_n = 1'b0, supply_ok = 1'b0, iface_sel = 1'b0;
  logic                 reg_dis = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic                 pready, pslverr, addr_match, reg_en, in_reset;
  logic [APB_AW-1:0]    paddr = '0;
  logic [APB_DW-1:0]    pwdata = '0, prdata, rd;
  logic [NUM_PADS-1:0]  strap_val = '0, rx_d = '0, pad_i, pad_o, pad_oe;
  logic [SM_ADDR_W-1:0] frame_addr = '0;
  logic [11:0]          cf;
  psl_phy_cfg_s         phy_cfg;
  int                   errors = 0, checked = 0;
  localparam logic [3:0] CX [8] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hC, 4'hC, 4'h0, 4'hD};
  localparam logic [3:0] AX [8] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'h4, 4'h0, 4'hF};
  localparam logic [7:0] CRS = 8'h95;
  assign cf = {phy_cfg.speed100, phy_cfg.aneg_en, phy_cfg.bit10, phy_cfg.full_duplex, phy_cfg.adv,
               phy_cfg.power_down, phy_cfg.repeater, phy_cfg.crs_tx, phy_cfg.rmii_sel};
  psl_strap_loader u_psl_strap_loader (.clk(clk), .sys_rst(sys_rst), .hw_reset_n(hw_reset_n), .supply_ok(supply_ok),
    .strap_pad_i(pad_i), .strap_pad_o(pad_o), .strap_pad_oe(pad_oe), .rx_drive_d(rx_d), .iface_select_strap(iface_sel),
    .regulator_disable_strap(reg_dis), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_addr(frame_addr),
    .addr_match(addr_match), .phy_cfg(phy_cfg), .core_regulator_en(reg_en), .in_reset(in_reset));
  psl_strap_model u_psl_strap_model (.strap_val(strap_val), .strap_pad_o(pad_o), .strap_pad_oe(pad_oe),
    .strap_pad_i(pad_i));
  // Clock and moving receive data
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) rx_d <= rx_d + 6'h1;
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One APB transfer, read data left in rd
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // Pin reset with given straps
  task automatic hw_cycle(input logic [2:0] m, input logic [2:0] a, input logic s);
    hw_reset_n <= 1'b0;
    strap_val <= {m, a};
    iface_sel <= s;
    frame_addr <= 5'(a);
    repeat (5) @(posedge clk);
    hw_reset_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : hw_cycle
  task automatic end_sim;
    if (errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  // Watchdog
  initial begin
    #20us;
    errors++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    supply_ok <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      hw_cycle(3'(i), 3'(i), i[0]);
      chk("cfg", {CX[i], AX[i], i == 6, i == 5, CRS[i], i[0]}, 32'(cf));
      apb(1'b0, OFS_SPECIAL, 32'h0);
      chk("special", (32'(i[0]) << SM_IFACE) | (32'(i) << SM_MODE_LSB) | 32'(i), rd);
      chk("match", 32'h1, 32'(addr_match));
    end
    apb(1'b1, OFS_SPECIAL, 32'hFA);
    chk("old_addr", 32'h0, 32'(addr_match));
    frame_addr <= 5'h1A;
    apb(1'b0, OFS_SPECIAL, 32'h0);
    chk("new_addr", 32'h1, 32'(addr_match));
    hw_cycle(3'h6, 3'h2, 1'b0);
    strap_val <= '0;
    apb(1'b1, OFS_SPECIAL, 32'h62);
    apb(1'b1, OFS_BASIC_CTRL, 32'h8000);
    repeat (4) @(posedge clk);
    chk("soft", 32'h12, 32'({cf[11:8], cf[3]}));
    apb(1'b0, 8'h20, 32'h0);
    chk("slverr", 32'h1, 32'(pslverr));
    chk("reg_on", 32'h1, 32'(reg_en));
    sys_rst <= 1'b1;
    supply_ok <= 1'b0;
    reg_dis <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    supply_ok <= 1'b1;
    repeat (6) @(posedge clk);
    chk("reg_off", 32'h0, 32'(reg_en));
    apb(1'b0, OFS_STRAP_STAT, 32'h0);
    chk("reg_stat", 32'h3, 32'(rd[SS_REG_SAMPLED:SS_REGULATOR_DISABLE_STRAP]));
    end_sim();
  end
endmodule : psl_strap_loader_tb
bind psl_strap_loader psl_strap_loader_sva u_psl_strap_loader_sva (.clk(clk), .sys_rst(sys_rst),
  .hw_reset_n(hw_reset_n), .psel(psel), .penable(penable), .pready(pready), .rx_drive_d(rx_drive_d),
  .strap_pad_o(strap_pad_o), .strap_pad_oe(strap_pad_oe), .frame_addr(frame_addr), .addr_match(addr_match),
  .phy_cfg(phy_cfg), .in_reset(in_reset));
`default_nettype wire
